/* File: inc/mac_ctrl_consts.vh */
// register offsets, field positions, reset values and timing for the mac control slice
`ifndef MAC_CTRL_CONSTS_VH
`define MAC_CTRL_CONSTS_VH
`define OFS_CORE_CTRL 12'h000
`define OFS_BUS_CTRL 12'h008
`define OFS_TX_IRQ_CTRL 12'h00C
`define OFS_RX_IRQ_CTRL 12'h010
`define OFS_TX_POLL_CMD 12'h014
`define OFS_RX_BUFFER_SIZE 12'h018
`define OFS_STATUS 12'h01C
`define RST_BUS_CTRL 16'h1F1A
`define RST_TX_IRQ_CTRL 16'h0000
`define RST_RX_IRQ_CTRL 16'h0000
`define RST_RX_BUFFER_SIZE 16'h0600
`define RST_BURST_BYTES 6'h10
`define RST_RX_BUF_BYTES 11'h600
`define MASK_BUS_CTRL 16'h1F3F
`define MASK_IRQ_CTRL 16'h0F3F
`define MASK_RX_BUFFER_SIZE 16'h07FC
`define URG_LSB 8
`define URG_MSB 12
`define RXTH_LSB 4
`define TXTH_LSB 2
`define BURST_LSB 0
`define CNT_LSB 8
`define TMR_LSB 0
`define TMR_BASE 12'd63
`define TMR_STEP 12'd64
`define RX_ON_BIT 1
`endif

/* File: rtl/mac_dma_irq_control.v */
// control slice of an ethernet mac: bus urgency, fifo thresholds, irq moderation, tx poll
`timescale 1ns/1ps
`default_nettype none
`include "mac_ctrl_consts.vh"
// What this block does
// - a new memory request loads the urgency countdown from bus_urgency_timer
// - urgency wait spans 1 to 31 host clocks; reset default 31
// - bus_urgency_timer of zero keeps requests at normal priority
// - rx moves data to memory only when fifo level exceeds rx threshold
// - rx threshold codes 0..3 mean 8,16,32,64 bytes; default code 01
// - tx starts sending only when tx fifo level exceeds tx threshold
// - tx threshold codes 0..3 mean 16,32,64,96 bytes; default code 10
// - burst size codes 0..3 mean 4,8,16,32 bytes; default 16 bytes
// - bus_ctrl accepts writes only while receive is off
// - nonzero tx packet count N raises irq after N sent; zero disables
// - tx wait timer fires irq after 63+64*field tx clocks
// - nonzero rx packet count N raises irq after N received; zero disables
// - rx wait timer fires irq after 63+64*field rx clocks
// - writing tx_kick makes the mac check the tx descriptor owner bit
// - owner bit 0 waits until it becomes 1, then transmission starts
// - reading tx_kick gives 1 while transmitting, 0 when done
// - rx_buffer_bytes bits 10..2 give one size for all rx buffers
// - rx_buffer_size accepts writes only while receive is off
// - rx_path_on set admits reception, cleared stops it
module mac_dma_irq_control (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire mem_req,
  input wire mem_grant,
  output reg mem_req_urgent,
  input wire [6:0] rx_fifo_level,
  output reg rx_dma_go,
  input wire [6:0] tx_fifo_level,
  output reg tx_send_go,
  output reg [5:0] burst_bytes,
  output reg [10:0] rx_buf_bytes,
  output reg rx_path_on,
  input wire tx_clk,
  input wire rx_clk,
  input wire tx_pkt_done,
  input wire rx_pkt_done,
  output reg tx_irq,
  output reg rx_irq,
  input wire tx_desc_owner,
  input wire tx_frame_done,
  output reg tx_start
);
  // fsm of the transmit poll command
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT_OWN = 3'b010;
  localparam [2:0] ST_SEND = 3'b100;

  reg [15:0] bus_ctrl_q;
  reg [15:0] tx_irq_ctrl_q;
  reg [15:0] rx_irq_ctrl_q;
  reg [15:0] rx_buffer_size_q;
  reg rx_on_q;
  reg [2:0] poll_q;
  reg [4:0] urg_cnt_q;
  reg urg_run_q;
  reg req_seen_q;
  reg [1:0] txc_s_q, rxc_s_q, txp_s_q, rxp_s_q, own_s_q;
  reg txc_d1_q, rxc_d1_q, txp_d1_q, rxp_d1_q;
  reg [3:0] tx_pkts_q, rx_pkts_q;
  reg [11:0] tx_tmr_q, rx_tmr_q;
  reg [31:0] rdata_d;

  wire wr_acc = psel && penable && pwrite;
  wire rd_acc = psel && penable && !pwrite;
  // no wait states: every access completes in its first access cycle
  wire known = (paddr == `OFS_CORE_CTRL) || (paddr == `OFS_BUS_CTRL) ||
    (paddr == `OFS_TX_IRQ_CTRL) || (paddr == `OFS_RX_IRQ_CTRL) ||
    (paddr == `OFS_TX_POLL_CMD) || (paddr == `OFS_RX_BUFFER_SIZE) ||
    (paddr == `OFS_STATUS);
  wire [4:0] urg_load = bus_ctrl_q[`URG_MSB:`URG_LSB];
  wire tx_edge = txc_s_q[1] && !txc_d1_q;
  wire rx_edge = rxc_s_q[1] && !rxc_d1_q;
  wire txp_edge = txp_s_q[1] && !txp_d1_q;
  wire rxp_edge = rxp_s_q[1] && !rxp_d1_q;

  // wait time in link clocks for a six bit timer field
  function [11:0] wait_len;
    input [5:0] f;
    begin
      wait_len = `TMR_BASE + {f, 6'b000000};
    end
  endfunction

  // fifo threshold code to bytes, rx table then tx table
  function [6:0] rx_thr;
    input [1:0] c;
    begin
      case (c)
        2'b00: rx_thr = 7'd8;
        2'b01: rx_thr = 7'd16;
        2'b10: rx_thr = 7'd32;
        default: rx_thr = 7'd64;
      endcase
    end
  endfunction

  function [6:0] tx_thr;
    input [1:0] c;
    begin
      case (c)
        2'b00: tx_thr = 7'd16;
        2'b01: tx_thr = 7'd32;
        2'b10: tx_thr = 7'd64;
        default: tx_thr = 7'd96;
      endcase
    end
  endfunction

  // register writes; bus_ctrl and rx_buffer_size locked while receive runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_ctrl_q <= `RST_BUS_CTRL;
      tx_irq_ctrl_q <= `RST_TX_IRQ_CTRL;
      rx_irq_ctrl_q <= `RST_RX_IRQ_CTRL;
      rx_buffer_size_q <= `RST_RX_BUFFER_SIZE;
      rx_on_q <= 1'b0;
    end else if (wr_acc) begin
      if (paddr == `OFS_CORE_CTRL) begin
        rx_on_q <= pwdata[`RX_ON_BIT];
      end
      // refused writes still complete; software sees no error
      if (paddr == `OFS_BUS_CTRL && !rx_on_q) begin
        bus_ctrl_q <= pwdata[15:0] & `MASK_BUS_CTRL;
      end
      if (paddr == `OFS_TX_IRQ_CTRL) begin
        tx_irq_ctrl_q <= pwdata[15:0] & `MASK_IRQ_CTRL;
      end
      if (paddr == `OFS_RX_IRQ_CTRL) begin
        rx_irq_ctrl_q <= pwdata[15:0] & `MASK_IRQ_CTRL;
      end
      // low two bits forced zero in case software breaks its side
      if (paddr == `OFS_RX_BUFFER_SIZE && !rx_on_q) begin
        rx_buffer_size_q <= pwdata[15:0] & `MASK_RX_BUFFER_SIZE;
      end
    end
  end

  // read mux
  always @* begin
    // reserved and unmapped bits read as zero
    rdata_d = 32'h00000000;
    case (paddr)
      `OFS_CORE_CTRL: rdata_d[`RX_ON_BIT] = rx_on_q;
      `OFS_BUS_CTRL: rdata_d[15:0] = bus_ctrl_q;
      `OFS_TX_IRQ_CTRL: rdata_d[15:0] = tx_irq_ctrl_q;
      `OFS_RX_IRQ_CTRL: rdata_d[15:0] = rx_irq_ctrl_q;
      `OFS_TX_POLL_CMD: rdata_d[0] = (poll_q != ST_IDLE);
      `OFS_RX_BUFFER_SIZE: rdata_d[15:0] = rx_buffer_size_q;
      `OFS_STATUS: rdata_d[3:0] = {mem_req_urgent, tx_start, rx_dma_go, tx_send_go};
      default: rdata_d = 32'h00000000;
    endcase
  end

  // apb answer, registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known;
      prdata <= (psel && !pwrite) ? rdata_d : 32'h00000000;
    end
  end

  // transmit poll: kick checks owner, waits for it, runs until frame done
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll_q <= ST_IDLE;
      tx_start <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      // new kicks are ignored while a frame is pending or being sent
      case (poll_q)
        ST_IDLE: begin
          if (wr_acc && paddr == `OFS_TX_POLL_CMD && pwdata[0]) begin
            poll_q <= ST_WAIT_OWN;
          end
        end
        ST_WAIT_OWN: begin
          if (own_s_q[1]) begin
            poll_q <= ST_SEND;
            tx_start <= 1'b1;
          end
        end
        ST_SEND: begin
          if (tx_frame_done) begin
            poll_q <= ST_IDLE;
          end
        end
        default: poll_q <= ST_IDLE;
      endcase
    end
  end

  // urgency countdown; restarts each time a new request rises
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      urg_cnt_q <= 5'd0;
      urg_run_q <= 1'b0;
      req_seen_q <= 1'b0;
      mem_req_urgent <= 1'b0;
    end else begin
      req_seen_q <= mem_req && !mem_grant;
      // grant, a dropped request or a zero field all cancel escalation
      if (!mem_req || mem_grant || urg_load == 5'd0) begin
        urg_run_q <= 1'b0;
        mem_req_urgent <= 1'b0;
      end else if (!req_seen_q) begin
        urg_cnt_q <= urg_load;
        urg_run_q <= 1'b1;
      end else if (urg_run_q) begin
        if (urg_cnt_q <= 5'd1) begin
          urg_run_q <= 1'b0;
          mem_req_urgent <= 1'b1;
        end else begin
          urg_cnt_q <= urg_cnt_q - 5'd1;
        end
      end
    end
  end

  // data path gating by thresholds and config outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_dma_go <= 1'b0;
      tx_send_go <= 1'b0;
      // start at the reset register decode so no bogus size shows
      burst_bytes <= `RST_BURST_BYTES;
      rx_buf_bytes <= `RST_RX_BUF_BYTES;
      rx_path_on <= 1'b0;
    end else begin
      rx_dma_go <= rx_on_q && (rx_fifo_level > rx_thr(bus_ctrl_q[`RXTH_LSB+1:`RXTH_LSB]));
      tx_send_go <= tx_fifo_level > tx_thr(bus_ctrl_q[`TXTH_LSB+1:`TXTH_LSB]);
      burst_bytes <= 6'd4 << bus_ctrl_q[`BURST_LSB+1:`BURST_LSB];
      rx_buf_bytes <= {rx_buffer_size_q[10:2], 2'b00};
      rx_path_on <= rx_on_q;
    end
  end

  // two-flop synchronisers for link clocks and their events
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txc_s_q <= 2'b00;
      rxc_s_q <= 2'b00;
      txp_s_q <= 2'b00;
      rxp_s_q <= 2'b00;
      own_s_q <= 2'b00;
      txc_d1_q <= 1'b0;
      rxc_d1_q <= 1'b0;
      txp_d1_q <= 1'b0;
      rxp_d1_q <= 1'b0;
    end else begin
      txc_s_q <= {txc_s_q[0], tx_clk};
      rxc_s_q <= {rxc_s_q[0], rx_clk};
      txp_s_q <= {txp_s_q[0], tx_pkt_done};
      rxp_s_q <= {rxp_s_q[0], rx_pkt_done};
      own_s_q <= {own_s_q[0], tx_desc_owner};
      // delayed copies give one-cycle rising edge strobes
      txc_d1_q <= txc_s_q[1];
      rxc_d1_q <= rxc_s_q[1];
      txp_d1_q <= txp_s_q[1];
      rxp_d1_q <= rxp_s_q[1];
    end
  end

  // tx moderation: packet count and wait timer, either fires the irq pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pkts_q <= 4'd0;
      tx_tmr_q <= 12'd0;
      tx_irq <= 1'b0;
    end else begin
      tx_irq <= 1'b0;
      // a packet irq wins over a timer irq in the same cycle
      if (tx_irq_ctrl_q[`CNT_LSB+3:`CNT_LSB] != 4'd0 && txp_edge &&
          tx_pkts_q + 4'd1 >= tx_irq_ctrl_q[`CNT_LSB+3:`CNT_LSB]) begin
        tx_irq <= 1'b1;
        tx_pkts_q <= 4'd0;
        tx_tmr_q <= 12'd0;
      end else if (tx_edge && tx_tmr_q + 12'd1 >= wait_len(tx_irq_ctrl_q[5:0])) begin
        tx_irq <= 1'b1;
        tx_tmr_q <= 12'd0;
        tx_pkts_q <= 4'd0;
      end else begin
        if (txp_edge) begin
          tx_pkts_q <= tx_pkts_q + 4'd1;
        end
        if (tx_edge) begin
          tx_tmr_q <= tx_tmr_q + 12'd1;
        end
      end
    end
  end

  // rx moderation mirrors tx on the rx link clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_pkts_q <= 4'd0;
      rx_tmr_q <= 12'd0;
      rx_irq <= 1'b0;
    end else begin
      rx_irq <= 1'b0;
      // either irq restarts both the packet count and the timer
      if (rx_irq_ctrl_q[`CNT_LSB+3:`CNT_LSB] != 4'd0 && rxp_edge &&
          rx_pkts_q + 4'd1 >= rx_irq_ctrl_q[`CNT_LSB+3:`CNT_LSB]) begin
        rx_irq <= 1'b1;
        rx_pkts_q <= 4'd0;
        rx_tmr_q <= 12'd0;
      end else if (rx_edge && rx_tmr_q + 12'd1 >= wait_len(rx_irq_ctrl_q[5:0])) begin
        rx_irq <= 1'b1;
        rx_tmr_q <= 12'd0;
        rx_pkts_q <= 4'd0;
      end else begin
        if (rxp_edge) begin
          rx_pkts_q <= rx_pkts_q + 4'd1;
        end
        if (rx_edge) begin
          rx_tmr_q <= rx_tmr_q + 12'd1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/mac_dma_irq_control_chk.sv */
// port assertions for the mac control slice
`timescale 1ns/1ps
`default_nettype none
module mac_dma_irq_control_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_req,
  input wire logic mem_req_urgent,
  input wire logic [6:0] rx_fifo_level,
  input wire logic rx_dma_go,
  input wire logic [6:0] tx_fifo_level,
  input wire logic tx_send_go,
  input wire logic [5:0] burst_bytes,
  input wire logic [10:0] rx_buf_bytes,
  input wire logic rx_path_on,
  input wire logic tx_irq,
  input wire logic rx_irq,
  input wire logic tx_desc_owner,
  input wire logic tx_start
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_access: assert property (s_setup |=> s_access)
    else $error("no ready in access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_urgent_late: assert property ($rose(mem_req) |=> !mem_req_urgent)
    else $error("urgent early");
  a_urgent_req: assert property (mem_req_urgent |-> $past(mem_req))
    else $error("urgent idle");
  a_rx_go_lvl: assert property (rx_dma_go |-> $past(rx_fifo_level) > 7'd8)
    else $error("rx go");
  a_tx_go_lvl: assert property (tx_send_go |-> $past(tx_fifo_level) > 7'd16)
    else $error("tx go");
  a_rx_go_on: assert property (rx_dma_go |-> rx_path_on)
    else $error("rx go while off");
  a_burst_code: assert property (burst_bytes inside {6'h04, 6'h08, 6'h10, 6'h20})
    else $error("burst");
  a_buf_align: assert property (rx_buf_bytes[1:0] == 2'b00)
    else $error("buf size");
  a_buf_locked: assert property (rx_path_on |-> $stable(rx_buf_bytes))
    else $error("buf size changed while receiving");
  a_burst_locked: assert property (rx_path_on |-> $stable(burst_bytes))
    else $error("burst changed while receiving");
  a_tx_irq_one: assert property (tx_irq |=> !tx_irq)
    else $error("tx irq long");
  a_rx_irq_one: assert property (rx_irq |=> !rx_irq)
    else $error("rx irq long");
  a_start_owner: assert property (tx_start |-> $past(tx_desc_owner, 3))
    else $error("no owner");
endmodule
`default_nettype wire

/* File: tb/mac_far_side.sv */
// arbiter and phy stand-in: grants, link clocks, frame completion
`timescale 1ns/1ps
`default_nettype none
module mac_far_side (
  input wire logic pclk,
  input wire logic mem_req,
  output logic mem_grant,
  input wire logic tx_start,
  output logic tx_desc_owner,
  output logic tx_frame_done,
  output logic tx_clk,
  output logic rx_clk
);
  int grant_wait = 2;
  int n = 0;
  // mii clocks run free; rx offset so the two never line up
  initial begin
    {mem_grant, tx_desc_owner, tx_frame_done, tx_clk, rx_clk} = '0;
    fork
      forever #32 tx_clk = ~tx_clk;
      begin
        #13;
        forever #32 rx_clk = ~rx_clk;
      end
    join_none
  end
  // grant only after a programmable wait, so urgency can expire
  always @(posedge pclk) begin
    n <= mem_req ? n + 1 : 0;
    mem_grant <= mem_req && (n >= grant_wait);
  end
  // a frame takes ten cycles on the wire
  always @(posedge pclk) begin
    if (tx_start === 1'b1) begin
      repeat (10) @(posedge pclk);
      tx_frame_done <= 1'b1;
      @(posedge pclk);
      tx_frame_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/mac_dma_irq_control_tb_top.sv */
// self-checking bench for the mac control slice
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
module mac_dma_irq_control_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mem_req = 0, err;
  logic tx_pkt_done = 0, rx_pkt_done = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r = 32'h6451838D;
  logic [6:0] rx_fifo_level = 0, tx_fifo_level = 0;
  logic pready, pslverr, mem_grant, mem_req_urgent, rx_dma_go, tx_send_go, rx_path_on;
  logic tx_clk, rx_clk, tx_irq, rx_irq, tx_desc_owner, tx_frame_done, tx_start;
  logic [5:0] burst_bytes;
  logic [10:0] rx_buf_bytes;
  int failures = 0, checked = 0, ntx = 0, nrx = 0, ctx = 0, crx = 0, gtx = 0, grx = 0, nst = 0;
  initial forever #4 pclk = ~pclk;
  mac_dma_irq_control u_mac_dma_irq_control (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_grant(mem_grant),
    .mem_req_urgent(mem_req_urgent), .rx_fifo_level(rx_fifo_level), .rx_dma_go(rx_dma_go),
    .tx_fifo_level(tx_fifo_level), .tx_send_go(tx_send_go), .burst_bytes(burst_bytes),
    .rx_buf_bytes(rx_buf_bytes), .rx_path_on(rx_path_on), .tx_clk(tx_clk), .rx_clk(rx_clk),
    .tx_pkt_done(tx_pkt_done), .rx_pkt_done(rx_pkt_done), .tx_irq(tx_irq), .rx_irq(rx_irq),
    .tx_desc_owner(tx_desc_owner), .tx_frame_done(tx_frame_done), .tx_start(tx_start));
  mac_far_side u_far (.pclk(pclk), .mem_req(mem_req), .mem_grant(mem_grant),
    .tx_start(tx_start), .tx_desc_owner(tx_desc_owner), .tx_frame_done(tx_frame_done),
    .tx_clk(tx_clk), .rx_clk(rx_clk));
  // pulse counts and the last gap between irq pulses
  always @(posedge pclk) begin
    ctx <= tx_irq === 1'b1 ? 0 : ctx + 1;
    crx <= rx_irq === 1'b1 ? 0 : crx + 1;
    if (tx_irq === 1'b1) begin
      gtx <= ctx + 1;
      ntx <= ntx + 1;
    end
    if (rx_irq === 1'b1) begin
      grx <= crx + 1;
      nrx <= nrx + 1;
    end
    if (tx_start === 1'b1) nst <= nst + 1;
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int thr(input bit rx, input int c);
    return rx ? 8 << c : (c == 3 ? 96 : 16 << c);
  endfunction
  function automatic int per(input int f);
    return (63 + 64 * f) * 8; // 64 ns link period over 8 ns host clock
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(0, a, 0, q);
    `CHK(q, e)
  endtask
  task automatic pkt();
    @(posedge pclk);
    tx_pkt_done <= 1;
    rx_pkt_done <= 1;
    repeat (4) @(posedge pclk);
    tx_pkt_done <= 0;
    rx_pkt_done <= 0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic urg(input int v, output int c);
    wr(12'h008, (v << 8) | 32'h1A);
    @(posedge pclk) mem_req <= 1;
    c = 0;
    while (mem_req_urgent !== 1'b1 && c < 40) begin
      @(posedge pclk);
      c++;
    end
    mem_req <= 0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // long enough for every scenario with a wide margin
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    end_of_test();
  end
  initial begin
    int n, c1, c;
    logic [31:0] v;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    // counted irqs first, with the timer field at 3F so its wait is too long to fire
    r = nx(r);
    n = 1 + r % 15;
    wr(12'h00C, (n << 8) | 32'h3F);
    wr(12'h010, (n << 8) | 32'h3F);
    repeat (n - 1) pkt();
    `CHK(ntx + nrx, 0)
    pkt();
    `CHK(ntx, 1)
    `CHK(nrx, 1)
    repeat (n) pkt();
    `CHK(ntx + nrx, 4)
    wr(12'h00C, 32'h3F);
    wr(12'h010, 32'h3F);
    repeat (3) pkt();
    `CHK(ntx + nrx, 4)
    rd(12'h008, 32'h1F1A);
    rd(12'h018, 32'h0600);
    `CHK(burst_bytes, 6'd16)
    rd(12'h040, 0);
    `CHK(err, 1'b1)
    for (int f = 0; f < 2; f++) begin
      wr(12'h00C, f);
      wr(12'h010, f);
      repeat (2 * per(f) + 40) @(posedge pclk);
      `CHK(gtx inside {[per(f) - 3:per(f) + 3]}, 1'b1)
      `CHK(grx inside {[per(f) - 3:per(f) + 3]}, 1'b1)
    end
    u_far.grant_wait = 1000;
    urg(1, c1);
    urg(15, c);
    `CHK(c - c1, 14)
    r = nx(r);
    urg(1 + r % 15, c);
    `CHK(c - c1, r % 15)
    urg(0, c);
    `CHK(c, 40)
    u_far.grant_wait = 0;
    urg(4, c);
    `CHK(c, 40)
    for (int k = 0; k < 4; k++) begin
      v = 32'h0F00 | (k << 4) | (k << 2) | k;
      wr(12'h000, 0);
      wr(12'h008, v);
      rd(12'h008, v);
      `CHK(burst_bytes, 6'd4 << k)
      wr(12'h000, 2);
      for (int j = 0; j < 3; j++) begin
        r = nx(r);
        rx_fifo_level <= j < 2 ? thr(1, k) + j : r[6:0];
        tx_fifo_level <= j < 2 ? thr(0, k) + j : r[14:8];
        repeat (3) @(posedge pclk);
        `CHK(rx_dma_go, rx_fifo_level > thr(1, k))
        `CHK(tx_send_go, tx_fifo_level > thr(0, k))
        `CHK(rx_path_on, 1'b1)
      end
      wr(12'h008, 0);
      rd(12'h008, v);
      wr(12'h018, 32'h7FC);
      rd(12'h018, 32'h0600);
    end
    wr(12'h000, 0);
    rx_fifo_level <= 7'h7F;
    repeat (3) @(posedge pclk);
    `CHK(rx_dma_go, 1'b0)
    `CHK(rx_path_on, 1'b0)
    rd(12'h000, 0);
    rd(12'h01C, tx_fifo_level > 7'd96);
    v = nx(r) & 32'h7FC;
    wr(12'h018, v);
    rd(12'h018, v);
    `CHK(rx_buf_bytes, v[10:0])
    u_far.tx_desc_owner <= 0;
    wr(12'h014, 1);
    repeat (20) @(posedge pclk);
    `CHK(nst, 0)
    rd(12'h014, 1);
    u_far.tx_desc_owner <= 1;
    repeat (8) @(posedge pclk);
    `CHK(nst, 1)
    repeat (16) @(posedge pclk);
    rd(12'h014, 0);
    end_of_test();
  end
endmodule
bind mac_dma_irq_control mac_dma_irq_control_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
  .mem_req_urgent(mem_req_urgent), .rx_fifo_level(rx_fifo_level), .rx_dma_go(rx_dma_go),
  .tx_fifo_level(tx_fifo_level), .tx_send_go(tx_send_go), .burst_bytes(burst_bytes),
  .rx_buf_bytes(rx_buf_bytes), .rx_path_on(rx_path_on), .tx_irq(tx_irq), .rx_irq(rx_irq),
  .tx_desc_owner(tx_desc_owner), .tx_start(tx_start));
`default_nettype wire
